// >>> lcd_pkg.sv
package lcd_pkg;
	localparam int RAM_DEPTH = 35;
	localparam int ADDR_W = 6;
	localparam int NIB_W = 4;
	localparam int SEG_N = 35;
	localparam logic [5:0] LAST_ADDR = 6'h22;
	localparam logic [5:0] FIRST_ADDR = 6'h00;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] NIB_MID = 3'h3;
	localparam logic [4:0] ALLPIX_CODE = 5'h1F;
	localparam logic [3:0] OPSET_CODE = 4'hD;
	localparam logic [1:0] PTR_CODE = 2'h0;
	localparam logic [1:0] MODE_CODE = 2'h2;
	localparam int OPSET_RST_BIT = 1;
	localparam int OPSET_MSB_BIT = 2;
	localparam int OPSET_CLK_BIT = 0;
	localparam int MODE_ON_BIT = 3;
	localparam int FORCE_ON_BIT = 1;
	localparam int FORCE_OFF_BIT = 0;

	typedef struct packed {
		logic is_cmd;
		logic [3:0] nib;
		logic last;
		logic [1:0] pad;
	} item_type;

	typedef struct packed {
		logic disp_on;
		logic force_on;
		logic force_off;
		logic addr_msb;
		logic ext_clk;
	} settings_type;
endpackage : lcd_pkg

// >>> lcd_serial_core.sv
`timescale 1ns/1ns
`default_nettype none
module lcd_serial_core (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic SELECT_N,
	input wire logic SERIAL_CLK,
	input wire logic SERIAL_IN,
	output logic [lcd_pkg::SEG_N*lcd_pkg::NIB_W-1:0] PIXELS,
	output logic DISPLAY_ON,
	output logic EXT_CLOCK_SEL,
	output logic [lcd_pkg::ADDR_W-1:0] POINTER
);
	////////////////////////////////////////////////////////////////
	// Input synchronisers; idle levels after reset so no false link edge appears
	localparam logic [2:0] PIN_IDLE = 3'h4;
	logic [2:0] pins;
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] s3_q;
	logic [2:0] s1_d;
	logic [2:0] s2_d;
	logic [2:0] s3_d;
	assign pins = {SELECT_N, SERIAL_CLK, SERIAL_IN};
	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_sync
			always_comb begin
				s1_d[p] = pins[p];
				s2_d[p] = s1_q[p];
				s3_d[p] = s2_q[p];
			end
			always_ff @(posedge CLK) begin
				if (SRST) begin
					s1_q[p] <= PIN_IDLE[p];
					s2_q[p] <= PIN_IDLE[p];
					s3_q[p] <= PIN_IDLE[p];
				end else begin
					s1_q[p] <= s1_d[p];
					s2_q[p] <= s2_d[p];
					s3_q[p] <= s3_d[p];
				end
			end
		end
	endgenerate
	logic sel_n, sck, sd, sck_rise, sck_fall;
	always_comb begin
		sel_n = s2_q[2];
		sck = s2_q[1];
		sd = s2_q[0];
		sck_rise = !sel_n && sck && !s3_q[1];
		sck_fall = !sel_n && !sck && s3_q[1];
	end

	////////////////////////////////////////////////////////////////
	// Shift receiver; emits nibbles into a two-entry buffer
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic eighth_q, eighth_d;
	logic in_valid, in_ready;
	lcd_pkg::item_type in_item;
	always_comb begin
		cnt_d = cnt_q;
		sh_d = sh_q;
		eighth_d = eighth_q;
		in_valid = 1'b0;
		in_item = '0;
		if (sel_n) begin
			cnt_d = '0;
			eighth_d = 1'b0;
		end else if (sck_rise) begin
			sh_d = {sh_q[6:0], sd};
			eighth_d = (cnt_q == lcd_pkg::BIT_LAST);
			cnt_d = cnt_q + 3'h1;
		end else if (sck_fall && eighth_q) begin
			// Whole byte at eighth falling edge; commands carry the full byte
			in_valid = 1'b1;
			eighth_d = 1'b0;
			in_item.is_cmd = sh_q[7];
			in_item.nib = sh_q[3:0];
			in_item.pad = sh_q[5:4];
		end
		if (sck_rise && cnt_q == lcd_pkg::NIB_MID) begin
			// Upper nibble of data complete after fourth bit; lower waits for eighth
			in_valid = !sh_q[2];
			in_item.is_cmd = 1'b0;
			in_item.nib = {sh_q[2:0], sd};
			in_item.last = 1'b0;
		end
		if (!in_ready) begin
			in_valid = 1'b0; // Stall drops the nibble; buffer is two deep so rare
		end
	end
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cnt_q <= '0;
			sh_q <= '0;
			eighth_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			eighth_q <= eighth_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Two-entry buffer; command bytes need the whole byte so keep it alongside
	logic [7:0] cmd_q [2];
	logic [7:0] cmd_d [2];
	lcd_pkg::item_type buf_q [2];
	lcd_pkg::item_type buf_d [2];
	logic [1:0] fill_q, fill_d;
	logic out_valid, out_ready;
	always_comb begin
		buf_d = buf_q;
		cmd_d = cmd_q;
		fill_d = fill_q;
		in_ready = (fill_q != 2'h2);
		out_valid = (fill_q != 2'h0);
		// Pop first, so a push in the same cycle lands behind the survivor
		if (out_valid && out_ready) begin
			buf_d[0] = buf_q[1];
			cmd_d[0] = cmd_q[1];
			fill_d = fill_d - 2'h1;
		end
		if (in_valid) begin
			buf_d[fill_d[0]] = in_item;
			cmd_d[fill_d[0]] = sh_q;
			fill_d = fill_d + 2'h1;
		end
	end
	always_ff @(posedge CLK) begin
		if (SRST) begin
			buf_q <= '{default: '0};
			cmd_q <= '{default: '0};
			fill_q <= '0;
		end else begin
			buf_q <= buf_d;
			cmd_q <= cmd_d;
			fill_q <= fill_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Interpreter
	typedef enum logic [5:0] {
		KIND_DATA = 6'h01,
		KIND_ALLPIX = 6'h02,
		KIND_OPSET = 6'h04,
		KIND_PTR = 6'h08,
		KIND_MODE = 6'h10,
		KIND_IGNORE = 6'h20
	} kind_type;
	logic [lcd_pkg::NIB_W-1:0] ram_q [lcd_pkg::RAM_DEPTH];
	logic [lcd_pkg::NIB_W-1:0] ram_d [lcd_pkg::RAM_DEPTH];
	logic [lcd_pkg::ADDR_W-1:0] ptr_q;
	logic [lcd_pkg::ADDR_W-1:0] ptr_d;
	lcd_pkg::settings_type set_q;
	lcd_pkg::settings_type set_d;
	logic [7:0] c;
	kind_type kind;
	// All-pixel and setup share the 11 prefix, so the longer code is tested first
	always_comb begin
		c = cmd_q[0];
		if (!buf_q[0].is_cmd) begin
			kind = KIND_DATA;
		end else if (c[6:2] == lcd_pkg::ALLPIX_CODE) begin
			kind = KIND_ALLPIX;
		end else if (c[6:3] == lcd_pkg::OPSET_CODE) begin
			kind = KIND_OPSET;
		end else if (c[6:5] == lcd_pkg::PTR_CODE) begin
			kind = KIND_PTR;
		end else if (c[6:5] == lcd_pkg::MODE_CODE) begin
			kind = KIND_MODE;
		end else begin
			// Waveform, bias and blink settings are not kept by this block
			kind = KIND_IGNORE;
		end
	end
	always_comb begin
		ram_d = ram_q;
		ptr_d = ptr_q;
		set_d = set_q;
		out_ready = 1'b1;
		if (out_valid) begin
			unique case (kind)
				KIND_DATA: begin
					// Writes to locations at or past RAM_DEPTH are dropped
					if (ptr_q < lcd_pkg::RAM_DEPTH) begin
						ram_d[ptr_q] = buf_q[0].nib;
					end
					if (ptr_q >= lcd_pkg::LAST_ADDR) begin
						ptr_d = lcd_pkg::FIRST_ADDR;
					end else begin
						ptr_d = ptr_q + 6'h01;
					end
				end
				KIND_ALLPIX: begin
					set_d.force_on = c[lcd_pkg::FORCE_ON_BIT];
					set_d.force_off = c[lcd_pkg::FORCE_OFF_BIT];
				end
				KIND_OPSET: begin
					if (c[lcd_pkg::OPSET_RST_BIT]) begin
						// Pointer and settings go back; the array keeps its words
						set_d = '0;
						ptr_d = lcd_pkg::FIRST_ADDR;
					end else begin
						set_d.addr_msb = c[lcd_pkg::OPSET_MSB_BIT];
						set_d.ext_clk = c[lcd_pkg::OPSET_CLK_BIT];
					end
				end
				KIND_PTR: begin
					ptr_d = {set_q.addr_msb, c[4:0]};
				end
				KIND_MODE: begin
					set_d.disp_on = c[lcd_pkg::MODE_ON_BIT];
				end
				KIND_IGNORE: begin
				end
			endcase
		end
	end
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ptr_q <= '0;
			set_q <= '0;
		end else begin
			ptr_q <= ptr_d;
			set_q <= set_d;
		end
		ram_q <= ram_d; // RAM has no reset, like the real array
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	logic [lcd_pkg::SEG_N*lcd_pkg::NIB_W-1:0] pix_d;
	genvar g;
	generate
		for (g = 0; g < lcd_pkg::SEG_N; g++) begin : g_seg
			always_comb begin
				if (!set_q.disp_on || set_q.force_off) begin
					pix_d[g*lcd_pkg::NIB_W +: lcd_pkg::NIB_W] = '0;
				end else if (set_q.force_on) begin
					pix_d[g*lcd_pkg::NIB_W +: lcd_pkg::NIB_W] = '1;
				end else begin
					pix_d[g*lcd_pkg::NIB_W +: lcd_pkg::NIB_W] = ram_q[g];
				end
			end
		end
	endgenerate
	logic out_on_d;
	logic out_ext_d;
	logic [lcd_pkg::ADDR_W-1:0] out_ptr_d;
	// Status follows the settings one cycle late, in step with the pixels
	always_comb begin
		out_on_d = set_q.disp_on;
		out_ext_d = set_q.ext_clk;
		out_ptr_d = ptr_q;
	end
	always_ff @(posedge CLK) begin
		if (SRST) begin
			PIXELS <= '0;
			DISPLAY_ON <= 1'b0;
			EXT_CLOCK_SEL <= 1'b0;
			POINTER <= '0;
		end else begin
			PIXELS <= pix_d;
			DISPLAY_ON <= out_on_d;
			EXT_CLOCK_SEL <= out_ext_d;
			POINTER <= out_ptr_d;
		end
	end
endmodule : lcd_serial_core
`default_nettype wire

// >>> lcd_serial_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module lcd_serial_core_assertions (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic SELECT_N,
	input wire logic SERIAL_CLK,
	input wire logic [139:0] PIXELS,
	input wire logic DISPLAY_ON,
	input wire logic EXT_CLOCK_SEL,
	input wire logic [5:0] POINTER
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	logic sclk_q;
	logic [3:0] quiet_q;
	logic [3:0] quiet_d;
	// Cycles since the link clock last moved, saturating
	always_comb quiet_d = (SERIAL_CLK != sclk_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
	always_ff @(posedge CLK) begin
		sclk_q <= SERIAL_CLK;
		quiet_q <= SRST ? 4'h0 : quiet_d;
	end
	reset_init_a: assert property ($fell(SRST) |-> POINTER == 6'h00 && !DISPLAY_ON
		&& !EXT_CLOCK_SEL && PIXELS == '0) else $error("reset");
	off_blank_a: assert property (!DISPLAY_ON [*2] |-> PIXELS == '0) else $error("blank");
	idle_ptr_a: assert property (SELECT_N [*8] |=> $stable(POINTER)) else $error("ptr");
	idle_cfg_a: assert property (SELECT_N [*8] |=> $stable(DISPLAY_ON)
		&& $stable(EXT_CLOCK_SEL)) else $error("cfg");
	idle_pix_a: assert property (SELECT_N [*8] |=> $stable(PIXELS)) else $error("pix");
	// Every change of POINTER, DISPLAY_ON or PIXELS must follow a link edge closely
	ptr_cause_a: assert property ($changed(POINTER) |-> quiet_q < 4'hC) else $error("p");
	cfg_cause_a: assert property ($changed(DISPLAY_ON) |-> quiet_q < 4'hC) else $error("c");
	pix_cause_a: assert property ($changed(PIXELS) |-> quiet_q < 4'hC) else $error("x");
	cover property ($fell(DISPLAY_ON));
	cover property (&PIXELS);
	cover property ($past(POINTER) == 6'h22 && POINTER == 6'h00);
endmodule : lcd_serial_core_assertions
bind lcd_serial_core lcd_serial_core_assertions chk (.CLK(CLK), .SRST(SRST), .SELECT_N(SELECT_N),
	.SERIAL_CLK(SERIAL_CLK), .PIXELS(PIXELS), .DISPLAY_ON(DISPLAY_ON),
	.EXT_CLOCK_SEL(EXT_CLOCK_SEL), .POINTER(POINTER));
`default_nettype wire

// >>> lcd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module lcd_host_model (
	output logic SELECT_N,
	output logic SERIAL_CLK,
	output logic SERIAL_IN
);
	initial begin
		SELECT_N = 1'b1;
		SERIAL_CLK = 1'b0;
		SERIAL_IN = 1'b0;
	end
	task automatic send(input logic [7:0] b, input int n);
		SELECT_N = 1'b0;
		#100;
		for (int i = 7; i > 7 - n; i--) begin
			SERIAL_IN = b[i];
			#100 SERIAL_CLK = 1'b1;
			#200 SERIAL_CLK = 1'b0;
			#100;
		end
		// Released data line must not keep the last bit
		SELECT_N = 1'b1;
		SERIAL_IN = ~SERIAL_IN;
		#400;
	endtask : send
endmodule : lcd_host_model
`default_nettype wire

// >>> lcd_serial_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module lcd_serial_core_tb;
	logic CLK, SRST, SELECT_N, SERIAL_CLK, SERIAL_IN, DISPLAY_ON, EXT_CLOCK_SEL;
	logic on, ext, fon, foff, msb;
	logic [139:0] PIXELS;
	logic [5:0] POINTER, ptr;
	logic [3:0] ram [35];
	logic [147:0] notes [$];
	logic [31:0] seed = 32'hAD4F;
	int failures = 0;
	int checked = 0;
	event ev;
	lcd_serial_core DUT (.CLK(CLK), .SRST(SRST), .SELECT_N(SELECT_N),
		.SERIAL_CLK(SERIAL_CLK), .SERIAL_IN(SERIAL_IN), .PIXELS(PIXELS),
		.DISPLAY_ON(DISPLAY_ON), .EXT_CLOCK_SEL(EXT_CLOCK_SEL), .POINTER(POINTER));
	lcd_host_model host (.SELECT_N(SELECT_N), .SERIAL_CLK(SERIAL_CLK), .SERIAL_IN(SERIAL_IN));
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic stop_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [3:0] n);
		if (ptr <= lcd_pkg::LAST_ADDR) ram[ptr] = n;
		ptr = (ptr == lcd_pkg::LAST_ADDR) ? 6'h00 : ptr + 6'h01;
	endtask : wr
	task automatic note();
		logic [139:0] p;
		for (int i = 0; i < 140; i++) p[i] = on && !foff && (fon || ram[i / 4][i % 4]);
		notes.push_back({ptr, on, ext, p});
		-> ev;
		$display("step done");
	endtask : note
	task automatic put(input logic [7:0] b, input int n);
		@(posedge CLK) #2;
		host.send(b, n);
		if (!b[7] && n > 3) wr(b[7:4]);
		if (!b[7] && n == 8) wr(b[3:0]);
		if (b[7] && n == 8) begin
			if (b[6:2] == 5'h1F) {fon, foff} = b[1:0];
			else if (b[6:3] == 4'hD && b[1]) {on, fon, foff, msb, ext, ptr} = '0;
			else if (b[6:3] == 4'hD) {msb, ext} = {b[2], b[0]};
			else if (b[6:5] == 2'h0) ptr = {msb, b[4:0]};
			else if (b[6:5] == 2'h2) on = b[3];
		end
		repeat (8) @(posedge CLK);
		#2 note();
	endtask : put
	task automatic check(input logic [147:0] seen, input logic [147:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected outputs exp %h seen %h", exp, seen);
		end
	endtask : check
	initial forever begin
		@(ev);
		check({POINTER, DISPLAY_ON, EXT_CLOCK_SEL, PIXELS}, notes.pop_front());
	end
	initial begin
		SRST = 1'b1;
		{on, ext, fon, foff, msb, ptr} = '0;
		repeat (20) @(posedge CLK);
		#2 SRST = 1'b0;
		note();
		for (int i = 0; i < 18; i++) begin
			seed = lfsr(seed);
			put({1'b0, seed[6:0]}, 8);
		end
		put(8'hC8, 8);
		put(8'hFE, 8);
		put(8'hFF, 8);
		put(8'hFC, 8);
		put({1'b0, seed[14:8]}, 3);
		put({1'b0, seed[22:16]}, 6);
		put(8'hEC, 8);
		put(8'h82, 8);
		put({1'b0, seed[30:24]}, 8);
		put(8'hE9, 8);
		put(8'hEA, 8);
		put(8'hC8, 8);
		stop_test();
	end
endmodule : lcd_serial_core_tb
`default_nettype wire
